// *** src/expander_map.svh ***
`ifndef EXPANDER_MAP_SVH
`define EXPANDER_MAP_SVH

// Fixed upper four target address bits, strap pins give the rest
`define TARGET_ADDR_HI  4'h4
// Position of the read/write bit in the address byte
`define RW_BIT          0
// Bits per byte on the bus
`define BYTE_BITS       4'h8

// Register codes taken from the low three command bits
`define CMD_INPUT0      3'h0
`define CMD_INPUT1      3'h1
`define CMD_DRIVE0      3'h2
`define CMD_DRIVE1      3'h3
`define CMD_INVERT0     3'h4
`define CMD_INVERT1     3'h5
`define CMD_DIR0        3'h6
`define CMD_DIR1        3'h7

// Register pair codes in command bits 2..1
`define PAIR_INPUT      2'h0
`define PAIR_DRIVE      2'h1
`define PAIR_INVERT     2'h2
`define PAIR_DIR        2'h3

// Reset values
`define RST_DRIVE       8'hFF
`define RST_INVERT      8'h00
`define RST_DIR         8'hFF
`define RST_POINTER     8'h00
`define RST_LEVEL       16'h0000

`endif

// *** src/expander_pkg.sv ***
package expander_pkg;

    // Bus engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_RX   = 3'b010,
        ST_ACK  = 3'b011,
        ST_TX   = 3'b100,
        ST_MACK = 3'b101,
        ST_WAIT = 3'b110
    } bus_state_t;

    // Per-port software settings
    typedef struct packed {
        logic [7:0] drive;
        logic [7:0] invert;
        logic [7:0] direction;
    } port_cfg_t;

endpackage : expander_pkg

// *** src/i2c_io_expander_regs.sv ***
// Contract
// RULE1: First byte after write address ack is stored as the command pointer.
// RULE2: Low three pointer bits select one of eight registers, codes 0 to 7.
// RULE3: Master sends command bytes only in write transfers, never in reads.
// RULE4: Pointer is kept across reads; only a new command byte or a repeated start changes it.
// RULE5: Input register reads return sampled pin levels whatever the direction.
// RULE6: Writes to input registers at codes 0 and 1 are dropped.
// RULE7: Drive registers reset to all ones and read back the stored flops.
// RULE8: A drive bit reaches its pin only while that pin is an output.
// RULE9: Inversion registers reset to zero; a one inverts that input bit.
// RULE10: Direction registers reset to ones; one is input, zero is output.
// RULE11: Write: address with bit 0, command byte, then data to selected register.
// RULE12: Each written data byte moves the target to the other pair register.
// RULE13: Any number of data bytes is accepted within one write.
// RULE14: Read: write address, command, repeated start, address with bit 1.
// RULE15: Repeated start overwrites the pointer with the register being accessed.
// RULE16: Each further read byte comes from the other register of the pair.
// RULE17: Pin levels are captured on the rising clock edge of the ack bit.
// RULE18: Master may read any count and answers the last byte with nack.
// RULE19: A stop may come anytime; data of the latest ack phase stays valid.
// RULE20: Target address is 0100 plus strap pins, last bit selects read.
// RULE21: Reading one port clears only that port's change indication.
// RULE22: Command bits 7 to 3 are ignored; only low three select a register.
`timescale 1ns/1ps
`include "expander_map.svh"

module i2c_io_expander_regs (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [2:0]  addr_strap,
    input  wire logic [15:0] pin_in,
    output logic      [15:0] pin_out,
    output logic      [15:0] pin_oe,
    output logic             irq_out,
    output logic             irq_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    expander_pkg::bus_state_t        state;
    expander_pkg::port_cfg_t [1:0]   cfg;
    logic                  scl_s1;
    logic                  scl_s2;
    logic                  scl_d;
    logic                  sda_s1;
    logic                  sda_s2;
    logic                  sda_d;
    logic [2:0]            strap_s1;
    logic [2:0]            strap_s2;
    logic [15:0]           pin_s1;
    logic [15:0]           pin_s2;
    logic [3:0]            bitcnt;
    logic [7:0]            shreg;
    logic                  rw;
    logic                  first;
    logic [2:0]            cur;
    logic [7:0]            pointer;
    logic [15:0]           in_level;
    logic [15:0]           base;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  bus_start;
    logic                  bus_stop;
    logic                  restart;
    logic                  byte_end;
    logic                  addr_hit;
    logic                  addr_take;
    logic                  cmd_take;
    logic                  wr_data;
    logic                  ack_rise;
    logic                  mack_rise;
    logic [7:0]            tx_byte;
    logic [15:0]           inv_bits;
    logic [15:0]           dir_bits;
    logic [1:0]            pending;

    ////////////////////////////////////////////////////////////////////////
    // Register read mux
    function automatic logic [7:0] read_byte(input logic [2:0] sel);
        logic [7:0] v;
        v = 8'h00;
        case (sel[2:1])
            `PAIR_INPUT:  v = sel[0] ? in_level[15:8] : in_level[7:0];   // [RULE5]
            `PAIR_DRIVE:  v = cfg[sel[0]].drive;                        // [RULE7]
            `PAIR_INVERT: v = cfg[sel[0]].invert;
            default:      v = cfg[sel[0]].direction;
        endcase
        return v;
    endfunction : read_byte

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers and a delay stage for edge detection
    always_ff @(posedge clk) begin
        if (!rstn) begin
            scl_s1   <= 1'b1;
            scl_s2   <= 1'b1;
            scl_d    <= 1'b1;
            sda_s1   <= 1'b1;
            sda_s2   <= 1'b1;
            sda_d    <= 1'b1;
            strap_s1 <= 3'h0;
            strap_s2 <= 3'h0;
            pin_s1   <= 16'h0000;
            pin_s2   <= 16'h0000;
        end else begin
            scl_s1   <= scl_in;
            scl_s2   <= scl_s1;
            scl_d    <= scl_s2;
            sda_s1   <= sda_in;
            sda_s2   <= sda_s1;
            sda_d    <= sda_s2;
            strap_s1 <= addr_strap;
            strap_s2 <= strap_s1;
            pin_s1   <= pin_in;
            pin_s2   <= pin_s1;
        end
    end

    // Bus events
    assign scl_rise  = scl_s2 & ~scl_d;
    assign scl_fall  = ~scl_s2 & scl_d;
    assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
    assign bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;
    assign restart   = bus_start && (state != expander_pkg::ST_IDLE);
    assign byte_end  = scl_fall && (bitcnt == `BYTE_BITS);
    assign addr_hit  = (shreg[7:1] == {`TARGET_ADDR_HI, strap_s2});           // [RULE20]
    assign addr_take = (state == expander_pkg::ST_ADDR) && byte_end && addr_hit;
    assign cmd_take  = (state == expander_pkg::ST_RX) && byte_end && first;
    assign wr_data   = (state == expander_pkg::ST_RX) && byte_end && !first;
    assign ack_rise  = scl_rise && ((state == expander_pkg::ST_ACK) ||
                                    (state == expander_pkg::ST_MACK));
    assign mack_rise = scl_rise && (state == expander_pkg::ST_MACK);

    // Byte to send, follows every register that the mux reads
    always_comb begin
        tx_byte = read_byte(cur);
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus engine: bit shifting, acks and byte sequencing
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state  <= expander_pkg::ST_IDLE;
            bitcnt <= 4'h0;
            shreg  <= 8'h00;
            rw     <= 1'b0;
            first  <= 1'b0;
            sda_oe <= 1'b0;
        end else if (bus_start) begin
            state  <= expander_pkg::ST_ADDR;
            bitcnt <= 4'h0;
            sda_oe <= 1'b0;
        end else if (bus_stop) begin
            state  <= expander_pkg::ST_IDLE;                                  // [RULE19]
            sda_oe <= 1'b0;
        end else begin
            case (state)
                expander_pkg::ST_ADDR, expander_pkg::ST_RX: begin
                    if (scl_rise) begin
                        shreg  <= {shreg[6:0], sda_s2};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (byte_end) begin
                        if (state == expander_pkg::ST_RX || addr_hit) begin
                            state  <= expander_pkg::ST_ACK;                   // [RULE13]
                            sda_oe <= 1'b1;
                        end else begin
                            state  <= expander_pkg::ST_IDLE;
                        end
                        if (state == expander_pkg::ST_ADDR) begin
                            rw    <= shreg[`RW_BIT];                          // [RULE11]
                            first <= ~shreg[`RW_BIT];                         // [RULE3]
                        end else begin
                            first <= 1'b0;
                        end
                    end
                end
                expander_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (rw) begin
                            state  <= expander_pkg::ST_TX;                    // [RULE14]
                            sda_oe <= ~tx_byte[7];
                            shreg  <= {tx_byte[6:0], 1'b0};
                            bitcnt <= 4'h1;
                        end else begin
                            state  <= expander_pkg::ST_RX;
                            sda_oe <= 1'b0;
                            bitcnt <= 4'h0;
                        end
                    end
                end
                expander_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bitcnt == `BYTE_BITS) begin
                            state  <= expander_pkg::ST_MACK;
                            sda_oe <= 1'b0;
                        end else begin
                            sda_oe <= ~shreg[7];
                            shreg  <= {shreg[6:0], 1'b0};
                            bitcnt <= bitcnt + 4'h1;
                        end
                    end
                end
                expander_pkg::ST_MACK: begin
                    if (scl_rise && sda_s2) begin
                        state <= expander_pkg::ST_WAIT;                       // [RULE18]
                    end else if (scl_fall) begin
                        state  <= expander_pkg::ST_TX;
                        sda_oe <= ~tx_byte[7];
                        shreg  <= {tx_byte[6:0], 1'b0};
                        bitcnt <= 4'h1;
                    end
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    assign sda_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Command pointer and current register select
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pointer <= `RST_POINTER;
            cur     <= `CMD_INPUT0;
        end else if (restart) begin
            pointer <= {5'h00, cur};                                          // [RULE15]
        end else if (cmd_take) begin
            pointer <= shreg;                                                 // [RULE1]
            cur     <= shreg[2:0];                                            // [RULE22]
        end else if (wr_data) begin
            cur     <= cur ^ 3'h1;                                            // [RULE12]
        end else if (addr_take && shreg[`RW_BIT]) begin
            cur     <= pointer[2:0];                                          // [RULE4]
        end else if (mack_rise && !sda_s2) begin
            cur     <= cur ^ 3'h1;                                            // [RULE16]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Settings registers written by data bytes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int p = 0; p < 2; p++) begin
                cfg[p].drive     <= `RST_DRIVE;                               // [RULE7]
                cfg[p].invert    <= `RST_INVERT;                              // [RULE9]
                cfg[p].direction <= `RST_DIR;                                 // [RULE10]
            end
        end else if (wr_data) begin
            if (cur[2:1] == `PAIR_DRIVE) begin                                // [RULE2]
                cfg[cur[0]].drive <= shreg;
            end else if (cur[2:1] == `PAIR_INVERT) begin
                cfg[cur[0]].invert <= shreg;
            end else if (cur[2:1] == `PAIR_DIR) begin
                cfg[cur[0]].direction <= shreg;
            end                                                               // [RULE6]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers per port
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_port
            assign pin_out[8*g +: 8]  = cfg[g].drive;
            assign pin_oe[8*g +: 8]   = ~cfg[g].direction;                    // [RULE8]
            assign inv_bits[8*g +: 8] = cfg[g].invert;
            assign dir_bits[8*g +: 8] = cfg[g].direction;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Input level capture at the ack clock rise
    always_ff @(posedge clk) begin
        if (!rstn) begin
            in_level <= `RST_LEVEL;
        end else if (ack_rise) begin
            in_level <= pin_s2 ^ inv_bits;                                    // [RULE17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-port change indication, cleared by reading that port
    always_ff @(posedge clk) begin
        if (!rstn) begin
            base <= `RST_LEVEL;
        end else if (mack_rise && (cur[2:1] == `PAIR_INPUT)) begin
            if (cur[0]) begin
                base[15:8] <= pin_s2[15:8];                                   // [RULE21]
            end else begin
                base[7:0]  <= pin_s2[7:0];
            end
        end
    end

    assign pending[0] = |((pin_s2[7:0] ^ base[7:0]) & dir_bits[7:0]);
    assign pending[1] = |((pin_s2[15:8] ^ base[15:8]) & dir_bits[15:8]);

    // Open-drain change output
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_oe <= 1'b0;
        end else begin
            irq_oe <= |pending;
        end
    end

    assign irq_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_cmd_store;
        cmd_take |=> (pointer == $past(shreg)) && (cur == $past(shreg[2:0]));
    endproperty
    a_cmd_store: assert property (p_cmd_store) else $error("command not stored"); // [RULE1]

    property p_decode;
        wr_data && (cur == `CMD_DRIVE1) |=> cfg[1].drive == $past(shreg);
    endproperty
    a_decode: assert property (p_decode) else $error("wrong register written"); // [RULE2]

    property p_keep;
        $changed(pointer) |-> $past(cmd_take) || $past(restart);
    endproperty
    a_keep: assert property (p_keep) else $error("pointer changed by itself"); // [RULE4]

    property p_input_ro;
        wr_data && (cur[2:1] == `PAIR_INPUT) |=> $stable(cfg);
    endproperty
    a_input_ro: assert property (p_input_ro) else $error("input write changed state"); // [RULE6]

    property p_reset_vals;
        $rose(rstn) |-> (cfg[0].drive == 8'hFF) && (cfg[1].invert == 8'h00)
                        && (pin_oe == 16'h0000);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset value"); // [RULE7]

    property p_dir;
        wr_data && (cur == `CMD_DIR0) |=> pin_oe[7:0] == ~$past(shreg);
    endproperty
    a_dir: assert property (p_dir) else $error("direction not applied"); // [RULE10]

    property p_wr_alt;
        wr_data |=> cur == ($past(cur) ^ 3'h1);
    endproperty
    a_wr_alt: assert property (p_wr_alt) else $error("write did not alternate"); // [RULE12]

    property p_restart;
        restart |=> pointer == {5'h00, $past(cur)};
    endproperty
    a_restart: assert property (p_restart) else $error("restart pointer wrong"); // [RULE15]

    property p_rd_alt;
        mack_rise && !sda_s2 |=> cur == ($past(cur) ^ 3'h1);
    endproperty
    a_rd_alt: assert property (p_rd_alt) else $error("read did not alternate"); // [RULE16]

    property p_capture;
        ack_rise |=> in_level == $past(pin_s2 ^ inv_bits);
    endproperty
    a_capture: assert property (p_capture) else $error("input not captured"); // [RULE17]

    property p_addr_miss;
        (state == expander_pkg::ST_ADDR) && byte_end && !addr_hit && !bus_start
            && !bus_stop |=> (state == expander_pkg::ST_IDLE) && !sda_oe;
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("acked foreign address"); // [RULE20]

    property p_port_clear;
        mack_rise && (cur == `CMD_INPUT1) |=> base[15:8] == $past(pin_s2[15:8])
                                              && $stable(base[7:0]);
    endproperty
    a_port_clear: assert property (p_port_clear) else $error("wrong port cleared"); // [RULE21]

    c_cmd: cover property (cmd_take);
    c_write: cover property (wr_data ##[1:400] wr_data);
    c_restart_read: cover property (restart ##[1:400] (state == expander_pkg::ST_TX));

endmodule : i2c_io_expander_regs

// *** tb/i2c_master_model.sv ***
`timescale 1ns/1ps

module i2c_master_model (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl = 1'b1,
    output logic      sda_drive_low = 1'b0
);
    // Lets n system clocks pass, then steps off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    // Start or repeated start, SDA falls while SCL high
    task automatic start();
        tick(2);
        sda_drive_low = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_drive_low = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask : start

    // Stop, SDA rises while SCL high; SCL then stays high
    task automatic stop();
        tick(2);
        sda_drive_low = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_drive_low = 1'b0;
        tick(4);
    endtask : stop

    // One bit: data set mid low phase, sampled late in high phase
    task automatic bit_io(input logic b, output logic s);
        tick(2);
        sda_drive_low = ~b;
        tick(2);
        scl = 1'b1;
        tick(3);
        s = sda_line;
        tick(1);
        scl = 1'b0;
    endtask : bit_io

    // Eight bits MSB first plus the ninth bit; ninth is ack or nack when reading
    task automatic xfer(input logic [7:0] d, input logic ninth, output logic [7:0] r,
                        output logic a);
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(ninth, a);
    endtask : xfer
endmodule : i2c_master_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`include "expander_map.svh"

module tb_top;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        scl;
    logic        m_low;
    logic        sda_line;
    logic        sda_out;
    logic        sda_oe;
    logic [2:0]  strap = 3'h5;
    logic [15:0] ext = 16'hA5C3;
    logic [15:0] pin_in;
    logic [15:0] pin_out;
    logic [15:0] pin_oe;
    logic        irq_out;
    logic        irq_oe;
    logic [15:0] drv = 16'hFFFF;
    logic [15:0] inv = 16'h0000;
    logic [15:0] dir = 16'hFFFF;
    int          failures = 0;
    int          samples_checked = 0;

    // Wired bus with pull-up; pins show drive when enabled, else outside level
    assign sda_line = ~(m_low | (sda_oe & ~sda_out));
    assign pin_in   = (pin_oe & pin_out) | (~pin_oe & ext);

    i2c_io_expander_regs i2c_io_expander_regs_inst (.clk(clk), .rstn(rstn), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(strap),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq_out(irq_out),
        .irq_oe(irq_oe));

    i2c_master_model i2c_master_model_inst (.clk(clk), .sda_line(sda_line), .scl(scl),
        .sda_drive_low(m_low));

    ////////////////////////////////////////////////////////////////////////////
    // Clock generation
    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Expected register contents from the tracked settings and pin levels
    function automatic logic [7:0] exp_reg(input logic [2:0] c);
        logic [15:0] v;
        case (c[2:1])
            2'h0: v = ((~dir & drv) | (dir & ext)) ^ inv;
            2'h1: v = drv;
            2'h2: v = inv;
            default: v = dir;
        endcase
        return c[0] ? v[15:8] : v[7:0];
    endfunction : exp_reg

    task automatic send(input logic [7:0] b, input logic ack, input string nm);
        logic [7:0] r;
        logic       a;
        i2c_master_model_inst.xfer(b, 1'b1, r, a);
        check(nm, {15'h0, a}, {15'h0, ~ack});
    endtask : send

    task automatic wr(input logic [7:0] c, input logic [7:0] q[$]);
        i2c_master_model_inst.start();
        send({`TARGET_ADDR_HI, strap, 1'b0}, 1'b1, "write addr ack");
        send(c, 1'b1, "command ack");
        foreach (q[i]) send(q[i], 1'b1, "data ack");
        i2c_master_model_inst.stop();
    endtask : wr

    task automatic rd(input logic [7:0] c, input bit cmd, input int n, output logic [7:0] r[$]);
        logic [7:0] b;
        logic       a;
        r = {};
        i2c_master_model_inst.start();
        if (cmd) begin
            send({`TARGET_ADDR_HI, strap, 1'b0}, 1'b1, "write addr ack");
            send(c, 1'b1, "command ack");
            i2c_master_model_inst.start();
        end
        send({`TARGET_ADDR_HI, strap, 1'b1}, 1'b1, "read addr ack");
        for (int i = 0; i < n; i++) begin
            i2c_master_model_inst.xfer(8'hFF, i == n - 1, b, a);
            r.push_back(b);
        end
        i2c_master_model_inst.stop();
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic sc_readback();
        logic [7:0] r[$];
        for (int c = 0; c < 8; c++) begin
            rd(c[7:0], 1'b1, 2, r);
            check("first byte", {8'h0, r[0]}, {8'h0, exp_reg(c[2:0])});
            check("pair byte", {8'h0, r[1]}, {8'h0, exp_reg(c[2:0] ^ 3'h1)});
        end
    endtask : sc_readback

    task automatic sc_reset();
        check("pin_out reset", pin_out, 16'hFFFF);
        check("pin_oe reset", pin_oe, 16'h0000);
        sc_readback();
    endtask : sc_reset

    task automatic sc_write();
        wr(8'h02, {8'hAA, 8'h55, 8'h33});
        drv = 16'h5533;
        wr(8'hFE, {8'h0F, 8'h3C});
        dir = 16'h3C0F;
        wr(8'h04, {8'hFF, 8'h0F});
        inv = 16'h0FFF;
        wr(8'h00, {8'h12, 8'h34});
        check("pin_out", pin_out, drv);
        check("pin_oe", pin_oe, ~dir);
        i2c_master_model_inst.tick(1);
        ext = 16'h3CA5;
        sc_readback();
    endtask : sc_write

    task automatic sc_pointer();
        logic [7:0] r[$];
        logic [7:0] b;
        logic       a;
        rd(8'h00, 1'b0, 1, r);
        check("kept pointer", {8'h0, r[0]}, {8'h0, exp_reg(3'h7)});
        i2c_master_model_inst.start();
        send({`TARGET_ADDR_HI, strap, 1'b0}, 1'b1, "write addr ack");
        send(8'h03, 1'b1, "command ack");
        i2c_master_model_inst.start();
        send({`TARGET_ADDR_HI, strap, 1'b1}, 1'b1, "read addr ack");
        i2c_master_model_inst.xfer(8'hFF, 1'b0, b, a);
        check("before restart", {8'h0, b}, {8'h0, exp_reg(3'h3)});
        i2c_master_model_inst.xfer(8'hFF, 1'b1, b, a);
        check("pair before restart", {8'h0, b}, {8'h0, exp_reg(3'h2)});
        i2c_master_model_inst.start();
        send({`TARGET_ADDR_HI, strap, 1'b1}, 1'b1, "read addr ack");
        i2c_master_model_inst.xfer(8'hFF, 1'b1, b, a);
        check("after restart", {8'h0, b}, {8'h0, exp_reg(3'h2)});
        i2c_master_model_inst.stop();
        rd(8'h00, 1'b0, 1, r);
        check("restart pointer", {8'h0, r[0]}, {8'h0, exp_reg(3'h2)});
    endtask : sc_pointer

    task automatic sc_address();
        logic [7:0] r[$];
        i2c_master_model_inst.start();
        send({`TARGET_ADDR_HI, strap ^ 3'h7, 1'b0}, 1'b0, "foreign addr");
        i2c_master_model_inst.stop();
        strap = 3'h2;
        i2c_master_model_inst.tick(4);
        wr(8'h03, {8'h81});
        drv[15:8] = 8'h81;
        check("pin_out strap", pin_out, drv);
        check("irq level", {15'h0, irq_out}, 16'h0000);
        check("irq settled", {15'h0, irq_oe}, 16'h0000);
        ext = ext ^ 16'h0400;
        i2c_master_model_inst.tick(6);
        check("irq raised", {15'h0, irq_oe}, 16'h0001);
        rd(8'h00, 1'b1, 1, r);
        check("port 0 read", {8'h0, r[0]}, {8'h0, exp_reg(3'h0)});
        check("irq kept", {15'h0, irq_oe}, 16'h0001);
        rd(8'h01, 1'b1, 1, r);
        check("port 1 read", {8'h0, r[0]}, {8'h0, exp_reg(3'h1)});
        check("irq cleared", {15'h0, irq_oe}, 16'h0000);
    endtask : sc_address

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence with a bounded watchdog beside it
    initial begin
        repeat (20) @(posedge clk);
        #2;
        rstn = 1'b1;
        i2c_master_model_inst.tick(5);
        sc_reset();
        sc_write();
        sc_pointer();
        sc_address();
        end_of_test();
    end

    initial begin
        repeat (80000) @(posedge clk);
        failures++;
        end_of_test();
    end
endmodule : tb_top
